/* design/rxife_encoder.sv */
`timescale 1ns/1ps
`include "rxife_defs.svh"

module rxife_encoder
  import rxife_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // received packet side
  input  wire logic        pay_valid,
  input  wire logic [7:0]  pay_byte,
  input  wire logic        expl_valid,
  input  wire rxife_expl_t expl_hdr,
  input  wire logic        io_valid,
  input  wire rxife_io_t   io_hdr,
  output logic             rx_ready,
  // serial frame byte stream
  output logic [7:0]       out_byte,
  output logic             out_valid,
  input  wire logic        out_ready
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] be_byte(input logic [63:0] w,
                                         input logic [2:0]  k);
    be_byte = w[8*(7-k) +: 8];
  endfunction

  function automatic logic vendor_ep(input logic [7:0] ep);
    vendor_ep = (ep >= `RXIFE_VEP_LO) && (ep <= `RXIFE_VEP_HI);
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]   api_output_option;
  logic [1:0]   api_escape_mode;
  logic         p2p_variant;
  logic [15:0]  rsv_value;
  logic         bad_method;
  logic [15:0]  frame_cnt;
  rxife_state_t state;
  rxife_state_t next_state;

  logic         take_expl;
  logic         take_io;
  logic         drop_bad;
  logic         frame_done;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      api_output_option <= `RXIFE_RST_AOPT;
      api_escape_mode   <= `RXIFE_RST_APMODE;
      p2p_variant       <= 1'b0;
      rsv_value         <= `RXIFE_RST_RSV;
    end else if (reg_wr && reg_addr == `RXIFE_REG_CTRL) begin
      api_output_option <= reg_wdata[7:0];
      api_escape_mode   <= reg_wdata[9:8];
      p2p_variant       <= reg_wdata[`RXIFE_CTRL_P2P];
    end else if (reg_wr && reg_addr == `RXIFE_REG_RSV) begin
      rsv_value         <= reg_wdata[15:0];
    end
  end

  // a new bad-method event wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bad_method <= 1'b0;
    end else if (drop_bad) begin
      bad_method <= 1'b1;
    end else if (reg_wr && reg_addr == `RXIFE_REG_STAT &&
                 reg_wdata[`RXIFE_STAT_BAD]) begin
      bad_method <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cnt <= 16'h0000;
    end else if (frame_done) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RXIFE_REG_CTRL: reg_rdata <= {21'h0, p2p_variant,
                                       api_escape_mode, api_output_option};
        `RXIFE_REG_RSV:  reg_rdata <= {16'h0000, rsv_value};
        `RXIFE_REG_STAT: reg_rdata <= {30'h0, bad_method,
                                       state != RXIFE_IDLE};
        `RXIFE_REG_CNT:  reg_rdata <= {16'h0000, frame_cnt};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // acceptance of a received packet
  // ------------------------------------------------------------
  logic accept_expl;
  logic accept_io;

  // explicit output takes priority when both arrive together
  assign accept_expl = rx_ready && expl_valid;
  assign accept_io   = rx_ready && io_valid && !expl_valid;
  // frames are only built in the mode that asks for them;
  // an invalid delivery method is never put on the wire
  assign take_expl   = accept_expl && (api_output_option > 8'd1)
                       && (expl_hdr.method != 2'b00);
  assign drop_bad    = accept_expl && (api_output_option > 8'd1)
                       && (expl_hdr.method == 2'b00);
  assign take_io     = accept_io && (api_output_option == 8'd0)
                       && (api_escape_mode != 2'd0);

  // ------------------------------------------------------------
  // payload store
  // ------------------------------------------------------------
  logic [7:0] pay_mem [0:`RXIFE_PAY_DEPTH-1];
  logic [6:0] pay_cnt;

  // bytes past the store depth are lost; the count saturates
  always_ff @(posedge core_clk) begin
    if (rx_ready && pay_valid && pay_cnt < 7'(`RXIFE_PAY_DEPTH)) begin
      pay_mem[pay_cnt[5:0]] <= pay_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pay_cnt <= 7'h00;
    end else if (accept_expl || accept_io) begin
      pay_cnt <= 7'h00;
    end else if (rx_ready && pay_valid &&
                 pay_cnt < 7'(`RXIFE_PAY_DEPTH)) begin
      pay_cnt <= pay_cnt + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // sample tail: digital word then enabled analog readings
  // ------------------------------------------------------------
  logic [7:0] next_tail [0:`RXIFE_TAIL_BYTES-1];
  logic [3:0] next_tail_n;
  logic [7:0] io_tail   [0:`RXIFE_TAIL_BYTES-1];

  always_comb begin
    for (int j = 0; j < `RXIFE_TAIL_BYTES; j++) begin
      next_tail[j] = 8'h00;
    end
    next_tail_n = 4'h0;
    if (io_hdr.dig_mask != 16'h0000) begin
      next_tail[0] = io_hdr.dig_sample[15:8];
      next_tail[1] = io_hdr.dig_sample[7:0];
      next_tail_n  = 4'h2;
    end
    for (int i = 0; i < 4; i++) begin
      if (io_hdr.ana_mask[i]) begin
        next_tail[next_tail_n]        = io_hdr.ana_sample[i][15:8];
        next_tail[next_tail_n + 4'h1] = io_hdr.ana_sample[i][7:0];
        next_tail_n = next_tail_n + 4'h2;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (take_io) begin
      for (int j = 0; j < `RXIFE_TAIL_BYTES; j++) begin
        io_tail[j] <= next_tail[j];
      end
    end
  end

  // ------------------------------------------------------------
  // captured frame fields
  // ------------------------------------------------------------
  logic        is_io;
  logic [63:0] src_addr;
  logic [7:0]  opt_byte;
  logic [7:0]  src_ep;
  logic [7:0]  dst_ep;
  logic [15:0] cluster;
  logic [15:0] profile;
  logic [7:0]  num_sets;
  logic [15:0] dig_mask;
  logic [7:0]  ana_mask;
  logic [15:0] frame_len;
  logic [7:0]  expl_opt;

  // outside the vendor endpoint range the option bits carry no meaning
  always_comb begin
    expl_opt = {expl_hdr.method, 1'b0,
                expl_hdr.secure, 1'b0,
                expl_hdr.all_net & p2p_variant,
                expl_hdr.bcast, expl_hdr.acked};
    if (!vendor_ep(expl_hdr.dst_ep)) begin
      expl_opt = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      is_io     <= 1'b0;
      src_addr  <= 64'h0;
      opt_byte  <= 8'h00;
      src_ep    <= 8'h00;
      dst_ep    <= 8'h00;
      cluster   <= 16'h0000;
      profile   <= 16'h0000;
      num_sets  <= 8'h00;
      dig_mask  <= 16'h0000;
      ana_mask  <= 8'h00;
      frame_len <= 16'h0000;
    end else if (take_expl) begin
      is_io     <= 1'b0;
      src_addr  <= expl_hdr.src_addr;
      opt_byte  <= expl_opt;
      src_ep    <= expl_hdr.src_ep;
      dst_ep    <= expl_hdr.dst_ep;
      cluster   <= expl_hdr.cluster;
      profile   <= expl_hdr.profile;
      frame_len <= `RXIFE_EXPL_FIXED + {9'h0, pay_cnt};
    end else if (take_io) begin
      is_io     <= 1'b1;
      src_addr  <= io_hdr.src_addr;
      opt_byte  <= {6'h00, io_hdr.bcast, io_hdr.acked};
      num_sets  <= io_hdr.num_sets;
      dig_mask  <= io_hdr.dig_mask;
      ana_mask  <= io_hdr.ana_mask;
      frame_len <= `RXIFE_IO_FIXED + {12'h0, next_tail_n};
    end
  end

  // ------------------------------------------------------------
  // byte at each frame offset
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic [7:0] last_idx;
  logic [7:0] cur_byte;
  logic [7:0] rel;
  logic [7:0] chk;

  assign last_idx = frame_len[7:0] + 8'd3;

  always_comb begin
    rel      = idx - `RXIFE_OFS_PAY;
    cur_byte = 8'h00;
    if (idx == 8'd0) begin
      cur_byte = `RXIFE_DELIM;
    end else if (idx == 8'd1) begin
      cur_byte = frame_len[15:8];
    end else if (idx == 8'd2) begin
      cur_byte = frame_len[7:0];
    end else if (idx == `RXIFE_OFS_TYPE) begin
      cur_byte = is_io ? `RXIFE_TYPE_IO : `RXIFE_TYPE_EXPL;
    end else if (idx < `RXIFE_OFS_RSV) begin
      cur_byte = be_byte(src_addr, 3'(idx - `RXIFE_OFS_ADDR));
    end else if (idx == `RXIFE_OFS_RSV) begin
      cur_byte = rsv_value[15:8];
    end else if (idx == `RXIFE_OFS_RSV + 8'd1) begin
      cur_byte = rsv_value[7:0];
    end else if (is_io) begin
      if (idx == `RXIFE_OFS_IOPT) begin
        cur_byte = opt_byte;
      end else if (idx == `RXIFE_OFS_NSMP) begin
        cur_byte = num_sets;
      end else if (idx == `RXIFE_OFS_DMSK) begin
        cur_byte = dig_mask[15:8];
      end else if (idx == `RXIFE_OFS_DMSK + 8'd1) begin
        cur_byte = dig_mask[7:0];
      end else if (idx == `RXIFE_OFS_AMSK) begin
        cur_byte = ana_mask;
      end else begin
        cur_byte = io_tail[4'(idx - `RXIFE_OFS_TAIL)];
      end
    end else begin
      if (idx == `RXIFE_OFS_SEP) begin
        cur_byte = src_ep;
      end else if (idx == `RXIFE_OFS_DEP) begin
        cur_byte = dst_ep;
      end else if (idx == `RXIFE_OFS_CLU) begin
        cur_byte = cluster[15:8];
      end else if (idx == `RXIFE_OFS_CLU + 8'd1) begin
        cur_byte = cluster[7:0];
      end else if (idx == `RXIFE_OFS_PRO) begin
        cur_byte = profile[15:8];
      end else if (idx == `RXIFE_OFS_PRO + 8'd1) begin
        cur_byte = profile[7:0];
      end else if (idx == `RXIFE_OFS_XOPT) begin
        cur_byte = opt_byte;
      end else begin
        cur_byte = pay_mem[rel[5:0]];
      end
    end
  end

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  logic load;
  logic start;

  assign start      = take_expl || take_io;
  assign load       = (state == RXIFE_SEND) && (!out_valid || out_ready);
  assign frame_done = (state == RXIFE_FLUSH) && out_ready;

  always_comb begin
    case (state)
      RXIFE_IDLE:  next_state = start ? RXIFE_SEND : RXIFE_IDLE;
      RXIFE_SEND:  next_state = (load && idx == last_idx) ? RXIFE_FLUSH
                                                          : RXIFE_SEND;
      RXIFE_FLUSH: next_state = out_ready ? RXIFE_IDLE : RXIFE_FLUSH;
      default:     next_state = RXIFE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= RXIFE_IDLE;
      rx_ready <= 1'b1;
    end else begin
      state    <= next_state;
      rx_ready <= (next_state == RXIFE_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idx <= 8'h00;
    end else if (start) begin
      idx <= 8'h00;
    end else if (load) begin
      idx <= idx + 8'h01;
    end
  end

  // the check byte is formed from the sum of every byte already loaded from the frame type on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_byte  <= 8'h00;
      out_valid <= 1'b0;
    end else if (load) begin
      out_byte  <= (idx == last_idx) ? chk : cur_byte;
      out_valid <= 1'b1;
    end else if (frame_done) begin
      out_valid <= 1'b0;
    end
  end

  rxife_sum u_sum (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clr      (start),
    .add_en   (load && idx >= `RXIFE_OFS_TYPE && idx != last_idx),
    .din      (cur_byte),
    .chk      (chk)
  );

endmodule

/* design/rxife_defs.svh */
`ifndef RXIFE_DEFS_SVH
`define RXIFE_DEFS_SVH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define RXIFE_DELIM        8'h7e
`define RXIFE_TYPE_EXPL    8'h91
`define RXIFE_TYPE_IO      8'h92
`define RXIFE_OFS_TYPE     8'd3
`define RXIFE_OFS_ADDR     8'd4
`define RXIFE_OFS_RSV      8'd12
`define RXIFE_OFS_SEP      8'd14
`define RXIFE_OFS_DEP      8'd15
`define RXIFE_OFS_CLU      8'd16
`define RXIFE_OFS_PRO      8'd18
`define RXIFE_OFS_XOPT     8'd20
`define RXIFE_OFS_PAY      8'd21
`define RXIFE_OFS_IOPT     8'd14
`define RXIFE_OFS_NSMP     8'd15
`define RXIFE_OFS_DMSK     8'd16
`define RXIFE_OFS_AMSK     8'd18
`define RXIFE_OFS_TAIL     8'd19
`define RXIFE_EXPL_FIXED   16'd18
`define RXIFE_IO_FIXED     16'd16
`define RXIFE_CHK_BASE     8'hff
`define RXIFE_VEP_LO       8'hdc
`define RXIFE_VEP_HI       8'hee
`define RXIFE_PAY_DEPTH    64
`define RXIFE_TAIL_BYTES   10

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define RXIFE_REG_CTRL     8'h00
`define RXIFE_REG_RSV      8'h04
`define RXIFE_REG_STAT     8'h08
`define RXIFE_REG_CNT      8'h0c
`define RXIFE_RST_AOPT     8'h00
`define RXIFE_RST_APMODE   2'h1
`define RXIFE_RST_RSV      16'hfffe
`define RXIFE_CTRL_P2P     10
`define RXIFE_STAT_BAD     1

`endif

/* design/rxife_pkg.sv */
package rxife_pkg;

  typedef struct packed {
    logic [63:0] src_addr;
    logic [7:0]  src_ep;
    logic [7:0]  dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic        acked;
    logic        bcast;
    logic        all_net;
    logic        secure;
    logic [1:0]  method;
  } rxife_expl_t;

  typedef struct packed {
    logic [63:0]      src_addr;
    logic             acked;
    logic             bcast;
    logic [7:0]       num_sets;
    logic [15:0]      dig_mask;
    logic [7:0]       ana_mask;
    logic [15:0]      dig_sample;
    logic [3:0][15:0] ana_sample;
  } rxife_io_t;

  typedef enum logic [1:0] {
    RXIFE_IDLE  = 2'b00,
    RXIFE_SEND  = 2'b01,
    RXIFE_FLUSH = 2'b11
  } rxife_state_t;

endpackage

/* design/rxife_sum.sv */
`timescale 1ns/1ps
`include "rxife_defs.svh"

// running modulo-256 sum of the covered bytes and the check byte
module rxife_sum
  import rxife_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       add_en,
  input  wire logic [7:0] din,
  output logic      [7:0] chk
);

  logic [7:0] sum;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sum <= 8'h00;
    end else if (clr) begin
      sum <= 8'h00;
    end else if (add_en) begin
      sum <= sum + din;
    end
  end

  assign chk = `RXIFE_CHK_BASE - sum;

endmodule

/* tb/rxife_monitor.sv */
`timescale 1ns/1ps
module rxife_monitor
  import rxife_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       rx_ready,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_valid,
  input  wire logic       out_ready
);
  // ----------------------------------------
  // frame position tracking
  // ----------------------------------------
  logic [15:0] idx;
  logic [15:0] flen;
  logic [7:0]  sum;
  logic [7:0]  ftype;
  logic [7:0]  fdst;
  logic        take;
  logic        last;
  logic        vend;
  assign take = out_valid && out_ready;
  assign last = idx >= 16'd3 && idx == flen + 16'd3;
  assign vend = fdst >= 8'hdc && fdst <= 8'hee;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idx   <= 16'h0;
      flen  <= 16'h0;
      sum   <= 8'h00;
      ftype <= 8'h00;
      fdst  <= 8'h00;
    end else if (take) begin
      idx <= last ? 16'h0 : idx + 16'h1;
      sum <= idx < 16'd3 ? 8'h00 : sum + out_byte;
      if (idx == 16'd1) flen[15:8] <= out_byte;
      if (idx == 16'd2) flen[7:0] <= out_byte;
      if (idx == 16'd3) ftype <= out_byte;
      if (idx == 16'd15) fdst <= out_byte;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("untaken byte changed");
  AST_DELIM: assert property (out_valid && idx == 16'h0 |-> out_byte == 8'h7e)
    else $error("frame start byte wrong");
  AST_START: assert property ($fell(rx_ready) |=> out_valid && idx == 16'h0)
    else $error("frame did not start");
  AST_TYPE: assert property (take && idx == 16'd3 |-> out_byte inside {8'h91, 8'h92})
    else $error("frame type wrong");
  AST_LEN: assert property (take && idx == 16'd4 |-> flen >= (ftype == 8'h91 ? 16'd18 : 16'd16))
    else $error("frame length too short");
  AST_SUM: assert property (take && last |-> 8'(sum + out_byte) == 8'hff)
    else $error("checksum wrong");
  AST_VENDOR: assert property (take && idx == 16'd20 && ftype == 8'h91 && !vend |-> out_byte == 8'h00)
    else $error("options set outside vendor range");
  AST_METHOD: assert property (take && idx == 16'd20 && ftype == 8'h91 && vend |-> out_byte[7:6] != 2'b00 && out_byte[5] == 1'b0)
    else $error("delivery method bits wrong");
  AST_IOOPT: assert property (take && idx == 16'd14 && ftype == 8'h92 |-> out_byte[7:2] == 6'h0)
    else $error("sample options carry extra bits");
  AST_RELEASE: assert property (take && last |=> !out_valid ##1 rx_ready)
    else $error("not idle after checksum");
  cover property (take && idx == 16'd3 && out_byte == 8'h91);
  cover property (take && idx == 16'd3 && out_byte == 8'h92);
  cover property (out_valid && !out_ready);
endmodule

bind rxife_encoder rxife_monitor rxife_monitor_i (
  .core_clk  (core_clk),
  .rstn      (rstn),
  .rx_ready  (rx_ready),
  .out_byte  (out_byte),
  .out_valid (out_valid),
  .out_ready (out_ready)
);

/* tb/rxife_host.sv */
`timescale 1ns/1ps
module rxife_host
  import rxife_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_valid,
  output logic            out_ready
);
  logic [7:0]  q[$];
  int          n_bad;
  int          idx;
  logic [15:0] len;
  logic [7:0]  sum;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_ready <= 1'b0;
      n_bad = 0;
      idx = 0;
      sum = 8'h00;
    end else begin
      // a slow host stalls every other cycle to exercise holding
      out_ready <= slow ? !out_ready : 1'b1;
      if (out_valid && out_ready) begin
        q.push_back(out_byte);
        if (idx == 1) len[15:8] = out_byte;
        if (idx == 2) len[7:0] = out_byte;
        if (idx >= 3) sum += out_byte;
        if (idx >= 3 && idx == len + 3) begin
          if (sum != 8'hff) n_bad++;
          idx = 0;
          sum = 8'h00;
        end else idx++;
      end
    end
  end
endmodule

/* tb/rxife_encoder_bench.sv */
`timescale 1ns/1ps
module rxife_encoder_bench
  import rxife_pkg::*;
;
  logic        core_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        pay_valid;
  logic [7:0]  pay_byte;
  logic        expl_valid;
  rxife_expl_t expl_hdr;
  logic        io_valid;
  rxife_io_t   io_hdr;
  logic        rx_ready;
  logic [7:0]  out_byte;
  logic        out_valid;
  logic        out_ready;
  logic        slow;
  logic [7:0]  eb[$];
  logic [7:0]  aopt;
  logic [1:0]  mode;
  logic        p2p;
  logic [15:0] rsv;
  int          fails;
  int          compares;

  rxife_encoder rxife_encoder_i (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pay_valid(pay_valid),
    .pay_byte(pay_byte), .expl_valid(expl_valid), .expl_hdr(expl_hdr),
    .io_valid(io_valid), .io_hdr(io_hdr), .rx_ready(rx_ready),
    .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready));
  rxife_host rxife_host_i (.core_clk(core_clk), .rstn(rstn), .slow(slow),
    .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("register read", reg_rdata, e);
  endtask

  task automatic ctl(logic [7:0] o, logic [1:0] md, logic p);
    aopt = o;
    mode = md;
    p2p = p;
    wr(8'h00, {21'h0, p, md, o});
  endtask

  task automatic put(logic [159:0] v, int n);
    for (int i = n - 1; i >= 0; i--) eb.push_back(v[8*i +: 8]);
  endtask

  task automatic feed(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      pay_valid <= 1'b1;
      pay_byte <= 8'h40 + 8'(i);
    end
    @(posedge core_clk);
    pay_valid <= 1'b0;
  endtask

  task automatic expect_frame();
    logic [7:0] s;
    logic [7:0] x[$];
    int         k;
    s = 8'h00;
    foreach (eb[i]) s += eb[i];
    x = {8'h7e, 8'(eb.size() >> 8), 8'(eb.size()), eb};
    x.push_back(8'hff - s);
    k = 0;
    while (!(rxife_host_i.q.size() >= x.size() && rx_ready) && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 3000) begin
      fails++;
      results();
    end else begin
      chk("frame size", rxife_host_i.q.size(), x.size());
      foreach (x[i]) chk("frame byte", rxife_host_i.q[i], x[i]);
      chk("bad host sums", rxife_host_i.n_bad, 0);
      rxife_host_i.q.delete();
      eb.delete();
    end
  endtask

  task automatic expect_none();
    repeat (20) @(negedge core_clk);
    chk("dropped frame bytes", rxife_host_i.q.size(), 0);
    eb.delete();
  endtask

  task automatic xframe(logic [1:0] m, logic [7:0] dep, int n);
    rxife_expl_t h;
    logic [7:0]  opt;
    h = '{64'h0102030405060708 + 64'(n), 8'h2a, dep, 16'h0011,
          16'h1e2f, 1'b1, m[0], 1'b1, m[1], m};
    opt = (dep >= 8'hdc && dep <= 8'hee) ?
          {m, 1'b0, m[1], 1'b0, p2p, m[0], 1'b1} : 8'h00;
    feed(n);
    expl_valid <= 1'b1;
    expl_hdr <= h;
    @(posedge core_clk);
    expl_valid <= 1'b0;
    put({8'h91, h.src_addr, rsv, 8'h2a, dep, 16'h0011, 16'h1e2f, opt}, 18);
    for (int i = 0; i < n; i++) put(8'h40 + 8'(i), 1);
    if (m != 2'b00 && aopt > 8'd1) expect_frame();
    else expect_none();
  endtask

  task automatic ioframe(logic [15:0] dm, logic [7:0] am);
    rxife_io_t h;
    h = '{64'h1122334455667788, 1'b1, 1'b1, 8'h01, dm, am,
          16'h0028, 64'h0444_0333_0222_0111};
    feed(0);
    io_valid <= 1'b1;
    io_hdr <= h;
    @(posedge core_clk);
    io_valid <= 1'b0;
    put({8'h92, h.src_addr, rsv, 8'h03, 8'h01, dm, am}, 16);
    if (dm != 16'h0) put(16'h0028, 2);
    for (int i = 0; i < 4; i++) if (am[i]) put(h.ana_sample[i], 2);
    if (aopt == 8'h0 && mode != 2'h0) expect_frame();
    else expect_none();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(8'h00, 32'h0000_0100);
    rchk(8'h04, 32'h0000_fffe);
    rchk(8'h10, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_expl();
    ctl(8'h02, 2'h1, 1'b0);
    xframe(2'b11, 8'he8, 6);
    slow <= 1'b1;
    xframe(2'b01, 8'hdc, 0);
    slow <= 1'b0;
    xframe(2'b10, 8'hee, 64);
    ctl(8'h02, 2'h1, 1'b1);
    xframe(2'b11, 8'hdc, 3);
    xframe(2'b11, 8'hef, 2);
    xframe(2'b11, 8'hdb, 1);
    $display("test explicit done");
  endtask

  task automatic t_drop();
    xframe(2'b00, 8'he8, 2);
    rchk(8'h08, 32'h2);
    wr(8'h08, 32'h2);
    rchk(8'h08, 32'h0);
    ctl(8'h01, 2'h1, 1'b0);
    xframe(2'b01, 8'he8, 2);
    $display("test drop done");
  endtask

  task automatic t_io();
    ctl(8'h00, 2'h1, 1'b0);
    ioframe(16'h0038, 8'h06);
    wr(8'h04, 32'h0000_87ac);
    rsv = 16'h87ac;
    ioframe(16'h0000, 8'h8f);
    xframe(2'b11, 8'he8, 1);
    ctl(8'h00, 2'h0, 1'b0);
    ioframe(16'h7fff, 8'h01);
    // sent frame counter: six explicit and two sample frames
    rchk(8'h0c, 32'd8);
    $display("test io done");
  endtask

  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pay_valid = 1'b0;
    pay_byte = 8'h00;
    expl_valid = 1'b0;
    expl_hdr = '0;
    io_valid = 1'b0;
    io_hdr = '0;
    slow = 1'b0;
    aopt = 8'h00;
    mode = 2'h1;
    p2p = 1'b0;
    rsv = 16'hfffe;
    fails = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_expl();
    t_drop();
    t_io();
    results();
  end
endmodule
